// ### rtl/psc_pkg.sv
// Constants and types for the salvo and chop mode controller.
// Summary of operation
// - Salvo key loads its salvo into preset.
// - Salvo mode ignores source and destination keys.
// - Category index appends; invalid name blinks.
// - Knob steps to next executable salvo.
// - Preset key enters preset selection mode.
// - Level key toggles; knob then steps levels.
// - Address key held shows polling address.
// - Protect: steady lamp, exclamation prefix.
// - Lock: blinking lamp, asterisk prefix.
// - Clear erases shown salvo selection.
// - Store enters store mode if valid.
// - Destination function to destination, salvo to direct.
// - Take or chop executes valid salvo only.
// - Chop: source key takes source, direct mode.
// - Chop: light keys of both chopped sources.
// - Chop: destination key sets destination, direct.
// - Chop: salvo key executes salvo, direct.
// - Chop ignores index, level, clear, store, knob.
// - Chop: destination, salvo, preset functions change mode.
// - Chop: take or chop restores prior source.
// - Chop swaps sources every half second.
package psc_pkg;

    // ==========================================================
    // Timing
    localparam int unsigned CLK_MHZ       = 250;
    localparam int unsigned CHOP_HALF_MS  = 500;
    localparam int unsigned CHOP_CYCLES   = CHOP_HALF_MS * CLK_MHZ * 1000;

    // ==========================================================
    // Register map
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_STATUS  = 8'h04;
    localparam logic [7:0] OFS_CHOPSRC = 8'h08;
    localparam logic [7:0] OFS_SALVO0  = 8'h10;
    localparam int unsigned SALVO_N    = 8;
    localparam int unsigned CTRL_LEVEL_BIT = 3;
    localparam int unsigned ENT_VALID_BIT  = 16;
    localparam int unsigned ENT_EXEC_BIT   = 17;
    localparam int unsigned CS_BOUNDA_BIT  = 8;
    localparam int unsigned CS_KEYB_LSB    = 16;
    localparam int unsigned CS_BOUNDB_BIT  = 24;
    localparam logic [31:0] RST_WORD   = 32'h0000_0000;

    // ==========================================================
    // Modes, key types, requests
    typedef enum logic [2:0] {
        MODE_DIRECT = 3'b000,
        MODE_PRESET = 3'b001,
        MODE_DEST   = 3'b010,
        MODE_SALVO  = 3'b011,
        MODE_STORE  = 3'b100,
        MODE_CHOP   = 3'b101
    } psc_mode_e;

    typedef enum logic [4:0] {
        KT_SRC      = 5'h00, KT_SOFTSRC  = 5'h01, KT_DEST     = 5'h02,
        KT_SOFTDEST = 5'h03, KT_DEDDEST  = 5'h04, KT_SALVO    = 5'h05,
        KT_SOFTSALVO= 5'h06, KT_CATIDX   = 5'h07, FN_PRESET   = 5'h08,
        FN_LEVEL    = 5'h09, FN_PROT     = 5'h0A, FN_LOCK     = 5'h0B,
        FN_CLEAR    = 5'h0C, FN_STORE    = 5'h0D, FN_DEST     = 5'h0E,
        FN_SALVO    = 5'h0F, FN_TAKE     = 5'h10, FN_CHOP     = 5'h11
    } psc_key_e;

    typedef enum logic [2:0] {
        REQ_NONE    = 3'b000,
        REQ_EXEC    = 3'b001,
        REQ_TAKESRC = 3'b010,
        REQ_SETDEST = 3'b011,
        REQ_SWAP    = 3'b100,
        REQ_PROTECT = 3'b101,
        REQ_LOCK    = 3'b110
    } psc_req_e;

    localparam logic [1:0] PFX_NONE = 2'h0;
    localparam logic [1:0] PFX_PROT = 2'h1;
    localparam logic [1:0] PFX_LOCK = 2'h2;

endpackage

// ### rtl/psc_chop_tick.sv
// Half-second enable pulse for chop swapping.
`timescale 1ns/1ps
`default_nettype none
module psc_chop_tick #(
    parameter int unsigned CYCLES = 125000000
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rstn,
    // Control
    input  wire logic run,
    output logic      tick
);
    logic [31:0] count;

    // ==========================================================
    // Divider restarts whenever chopping stops, so every chop starts a full period.
    always_ff @(posedge clk_sys) begin
        if (!rstn || !run) begin
            count <= 32'h0000_0000;
            tick  <= 1'b0;
        end else if (count == CYCLES - 1) begin
            count <= 32'h0000_0000;
            tick  <= 1'b1;
        end else begin
            count <= count + 32'h0000_0001;
            tick  <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ### rtl/psc_salvo_scan.sv
// Finds the next executable salvo after a given table slot.
`timescale 1ns/1ps
`default_nettype none
module psc_salvo_scan
    import psc_pkg::*;
(
    // Table flags
    input  wire logic [SALVO_N-1:0] valid,
    input  wire logic [SALVO_N-1:0] exec,
    // Search start and result
    input  wire logic [2:0]         start,
    output logic [2:0]              nextIdx,
    output logic                    found
);
    // Table is kept in alphabetical order by software, so slot order is name order.
    always_comb begin
        logic [3:0] k;
        k       = 4'h0;
        nextIdx = start;
        found   = 1'b0;
        for (int i = SALVO_N; i >= 1; i--) begin
            k = 4'(start) + 4'(i);
            if (valid[k[2:0]] && exec[k[2:0]]) begin
                nextIdx = k[2:0];
                found   = 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ### rtl/psc_ctrl.sv
// Salvo selection and chop mode key interpreter with AHB-Lite registers.
`timescale 1ns/1ps
`default_nettype none
module psc_ctrl
    import psc_pkg::*;
#(
    parameter int unsigned CHOP_COUNT = CHOP_CYCLES
) (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // Keypad events
    input  wire logic        keyEvt,
    input  wire logic [4:0]  keyType,
    input  wire logic [15:0] keyArg,
    input  wire logic        knobEvt,
    input  wire logic        addrHeld,
    input  wire logic [7:0]  pollAddr,
    // Requests to the routing controller
    output logic             reqValid,
    output logic [2:0]       reqCode,
    output logic [15:0]      reqArg,
    output logic             levelStep,
    // Display and lamps
    output logic [15:0]      presetShow,
    output logic             presetBlink,
    output logic             levelLamp,
    output logic             guardLamp,
    output logic             guardBlink,
    output logic [1:0]       destPrefix,
    output logic [7:0]       lampKeyA,
    output logic             lampAOn,
    output logic [7:0]       lampKeyB,
    output logic             lampBOn
);
    // ==========================================================
    // State
    psc_mode_e          mode,        next_mode;
    logic [15:0]        presetName,  next_name;
    logic               nameBlink,   next_blink;
    logic               nameShown,   next_shown;
    logic [7:0]         catSel,      next_cat;
    logic               catValid,    next_catValid;
    logic               levelActive, next_level;
    logic [2:0]         salvoIdx,    next_idx;
    logic [1:0]         guardState,  next_guard;
    logic               chopOdd;
    logic               swapTick;
    logic               doReq;
    logic               doLevelStep;
    psc_req_e           rc;
    logic [15:0]        ra;
    logic [15:0]        salvoName [SALVO_N];
    logic [SALVO_N-1:0] salvoValid;
    logic [SALVO_N-1:0] salvoExec;
    logic [31:0]        chopSrc;
    logic [2:0]         scanIdx;
    logic               scanFound;
    logic               wrPend;
    logic [7:0]         wrAddr;
    logic               swWr;
    logic               keyIsSrc, keyIsDest, keyIsSalvo;

    function automatic logic nameValid(input logic [15:0] n);
        nameValid = 1'b0;
        for (int i = 0; i < SALVO_N; i++) begin
            if (salvoValid[i] && salvoName[i] == n) begin
                nameValid = 1'b1;
            end
        end
    endfunction

    assign keyIsSrc   = keyType == KT_SRC || keyType == KT_SOFTSRC;
    assign keyIsDest  = keyType == KT_DEST || keyType == KT_SOFTDEST || keyType == KT_DEDDEST;
    assign keyIsSalvo = keyType == KT_SALVO || keyType == KT_SOFTSALVO;

    psc_salvo_scan u_scan (
        .valid   (salvoValid),
        .exec    (salvoExec),
        .start   (salvoIdx),
        .nextIdx (scanIdx),
        .found   (scanFound)
    );

    psc_chop_tick #(.CYCLES(CHOP_COUNT)) u_tick (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .run     (mode == MODE_CHOP),
        .tick    (swapTick)
    );

    // ==========================================================
    // Event interpreter: a key wins over the knob and a chop swap; the knob is ignored in chop mode and never blocks a swap.
    always_comb begin
        next_mode     = mode;
        next_name     = presetName;
        next_blink    = nameBlink;
        next_shown    = nameShown;
        next_cat      = catSel;
        next_catValid = catValid;
        next_level    = levelActive;
        next_idx      = salvoIdx;
        next_guard    = guardState;
        doReq         = 1'b0;
        rc            = REQ_NONE;
        ra            = 16'h0000;
        doLevelStep   = 1'b0;
        if (keyEvt) begin
            if (keyType == FN_PROT) begin
                next_guard = PFX_PROT;
                doReq      = 1'b1;
                rc         = REQ_PROTECT;
            end else if (keyType == FN_LOCK) begin
                next_guard = PFX_LOCK;
                doReq      = 1'b1;
                rc         = REQ_LOCK;
            end else if (mode == MODE_SALVO) begin
                if (keyIsSalvo) begin
                    next_name  = keyArg;
                    next_blink = !nameValid(keyArg);
                    next_shown = 1'b1;
                end else if (keyType == KT_CATIDX) begin
                    if (catValid) begin
                        next_name  = {catSel, keyArg[7:0]};
                        next_blink = !nameValid({catSel, keyArg[7:0]});
                        next_shown = 1'b1;
                    end else begin
                        next_cat      = keyArg[7:0];
                        next_catValid = 1'b1;
                    end
                end else if (keyType == FN_PRESET) begin
                    next_mode = MODE_PRESET;
                end else if (keyType == FN_LEVEL) begin
                    next_level = !levelActive;
                end else if (keyType == FN_CLEAR) begin
                    next_name     = 16'h0000;
                    next_blink    = 1'b0;
                    next_shown    = 1'b0;
                    next_catValid = 1'b0;
                end else if (keyType == FN_STORE) begin
                    if (nameShown && !nameBlink) begin
                        next_mode = MODE_STORE;
                    end
                end else if (keyType == FN_DEST) begin
                    next_mode = MODE_DEST;
                end else if (keyType == FN_SALVO) begin
                    next_mode = MODE_DIRECT;
                end else if (keyType == FN_TAKE || keyType == FN_CHOP) begin
                    if (nameShown && !nameBlink) begin
                        doReq = 1'b1;
                        rc    = REQ_EXEC;
                        ra    = presetName;
                    end
                end
                // Source and destination keys fall through untouched.
            end else if (mode == MODE_CHOP) begin
                if (keyIsSrc) begin
                    next_mode = MODE_DIRECT;
                    doReq     = 1'b1;
                    rc        = REQ_TAKESRC;
                    ra        = keyArg;
                end else if (keyIsDest) begin
                    next_mode = MODE_DIRECT;
                    doReq     = 1'b1;
                    rc        = REQ_SETDEST;
                    ra        = keyArg;
                end else if (keyIsSalvo) begin
                    next_mode = MODE_DIRECT;
                    doReq     = 1'b1;
                    rc        = REQ_EXEC;
                    ra        = keyArg;
                end else if (keyType == FN_DEST) begin
                    next_mode = MODE_DEST;
                end else if (keyType == FN_SALVO) begin
                    next_mode = MODE_SALVO;
                end else if (keyType == FN_PRESET) begin
                    next_mode = MODE_PRESET;
                end else if (keyType == FN_TAKE || keyType == FN_CHOP) begin
                    next_mode = MODE_DIRECT;
                    if (chopOdd) begin
                        doReq = 1'b1;
                        rc    = REQ_SWAP;
                    end
                end
                // Index, level, clear and store keys are dropped here.
            end
        end else if (knobEvt && mode != MODE_CHOP) begin
            if (levelActive) begin
                doLevelStep = 1'b1;
            end else if (mode == MODE_SALVO && scanFound) begin
                next_idx   = scanIdx;
                next_name  = salvoName[scanIdx];
                next_blink = 1'b0;
                next_shown = 1'b1;
            end
        end else if (mode == MODE_CHOP && swapTick) begin
            doReq = 1'b1;
            rc    = REQ_SWAP;
        end else if (swWr && wrAddr == OFS_CTRL) begin
            next_mode = psc_mode_e'(hwdata[2:0]);
        end
    end

    // ==========================================================
    // Mode and preset state
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            mode        <= MODE_DIRECT;
            presetName  <= 16'h0000;
            nameBlink   <= 1'b0;
            nameShown   <= 1'b0;
            catSel      <= 8'h00;
            catValid    <= 1'b0;
            levelActive <= 1'b0;
            salvoIdx    <= 3'h7;
            guardState  <= PFX_NONE;
        end else begin
            mode        <= next_mode;
            presetName  <= next_name;
            nameBlink   <= next_blink;
            nameShown   <= next_shown;
            catSel      <= next_cat;
            catValid    <= next_catValid;
            levelActive <= next_level;
            salvoIdx    <= next_idx;
            guardState  <= next_guard;
        end
    end

    // Parity of swaps since chop began decides whether leaving needs one more swap.
    always_ff @(posedge clk_sys) begin
        if (!rstn || mode != MODE_CHOP) begin
            chopOdd <= 1'b0;
        end else if (doReq && rc == REQ_SWAP) begin
            chopOdd <= !chopOdd;
        end
    end

    // ==========================================================
    // Requests and display outputs
    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            reqValid  <= 1'b0;
            reqCode   <= REQ_NONE;
            reqArg    <= 16'h0000;
            levelStep <= 1'b0;
        end else begin
            reqValid  <= doReq;
            reqCode   <= rc;
            reqArg    <= ra;
            levelStep <= doLevelStep;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            presetShow  <= 16'h0000;
            presetBlink <= 1'b0;
            levelLamp   <= 1'b0;
            guardLamp   <= 1'b0;
            guardBlink  <= 1'b0;
            destPrefix  <= PFX_NONE;
            lampKeyA    <= 8'h00;
            lampAOn     <= 1'b0;
            lampKeyB    <= 8'h00;
            lampBOn     <= 1'b0;
        end else begin
            presetShow  <= addrHeld ? {8'h00, pollAddr} : presetName;
            presetBlink <= !addrHeld && nameShown && nameBlink;
            levelLamp   <= levelActive;
            guardLamp   <= guardState != PFX_NONE;
            guardBlink  <= guardState == PFX_LOCK;
            destPrefix  <= guardState;
            lampKeyA    <= chopSrc[7:0];
            lampAOn     <= mode == MODE_CHOP && chopSrc[CS_BOUNDA_BIT];
            lampKeyB    <= chopSrc[CS_KEYB_LSB +: 8];
            lampBOn     <= mode == MODE_CHOP && chopSrc[CS_BOUNDB_BIT];
        end
    end

    // ==========================================================
    // AHB-Lite slave: zero wait states, always OKAY.
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign swWr      = wrPend;

    function automatic logic [31:0] regRead(input logic [7:0] a);
        logic [7:0] e;
        e = a - OFS_SALVO0;
        if (a == OFS_CTRL) begin
            regRead = {28'h0000000, levelActive, mode};
        end else if (a == OFS_STATUS) begin
            regRead = {11'h000, destPrefix, chopOdd, nameShown, nameBlink, presetName};
        end else if (a == OFS_CHOPSRC) begin
            regRead = chopSrc;
        end else if (a >= OFS_SALVO0 && e < 8'(SALVO_N * 4)) begin
            regRead = {14'h0000, salvoExec[e[4:2]], salvoValid[e[4:2]], salvoName[e[4:2]]};
        end else begin
            regRead = RST_WORD;
        end
    endfunction

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            wrPend <= 1'b0;
            wrAddr <= 8'h00;
            hrdata <= RST_WORD;
        end else begin
            wrPend <= hsel && hready && htrans[1] && hwrite;
            wrAddr <= {haddr[7:2], 2'b00};
            if (hsel && hready && htrans[1] && !hwrite) begin
                hrdata <= regRead({haddr[7:2], 2'b00});
            end
        end
    end

    // Table and chop source registers; an unmapped write is dropped.
    always_ff @(posedge clk_sys) begin
        logic [7:0] e;
        e = wrAddr - OFS_SALVO0;
        if (!rstn) begin
            chopSrc    <= RST_WORD;
            salvoValid <= '0;
            salvoExec  <= '0;
            for (int i = 0; i < SALVO_N; i++) begin
                salvoName[i] <= 16'h0000;
            end
        end else if (wrPend) begin
            if (wrAddr == OFS_CHOPSRC) begin
                chopSrc <= hwdata;
            end else if (wrAddr >= OFS_SALVO0 && e < 8'(SALVO_N * 4)) begin
                salvoName[e[4:2]]  <= hwdata[15:0];
                salvoValid[e[4:2]] <= hwdata[ENT_VALID_BIT];
                salvoExec[e[4:2]]  <= hwdata[ENT_EXEC_BIT];
            end
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    chk_salvo_load: assert property (
        keyEvt && mode == MODE_SALVO && keyIsSalvo |=> presetName == $past(keyArg))
        else $error("salvo key did not load preset");
    chk_salvo_ignore: assert property (
        keyEvt && mode == MODE_SALVO && (keyIsSrc || keyIsDest)
        |=> mode == MODE_SALVO && $stable(presetName) && !reqValid)
        else $error("salvo mode reacted to source or destination key");
    chk_cat_append: assert property (
        keyEvt && mode == MODE_SALVO && keyType == KT_CATIDX && catValid
        |=> presetName[7:0] == $past(keyArg[7:0]) && presetName[15:8] == $past(catSel))
        else $error("index not appended");
    chk_level_knob: assert property (
        knobEvt && !keyEvt && levelActive && mode == MODE_SALVO
        |=> $stable(presetName) && levelStep)
        else $error("knob not steered to level");
    chk_addr_show: assert property (
        addrHeld |=> presetShow == {8'h00, $past(pollAddr)})
        else $error("address not shown");
    chk_guard_lock: assert property (
        keyEvt && keyType == FN_LOCK |=> ##1 guardBlink && guardLamp && destPrefix == PFX_LOCK)
        else $error("lock not shown");
    chk_exec_valid: assert property (
        reqValid && reqCode == REQ_EXEC && $past(mode) == MODE_SALVO
        |-> $past(nameShown) && !$past(nameBlink))
        else $error("salvo executed while invalid");
    chk_chop_exit: assert property (
        keyEvt && mode == MODE_CHOP && keyType == FN_TAKE && chopOdd
        |=> mode == MODE_DIRECT && reqValid && reqCode == REQ_SWAP)
        else $error("chop exit did not restore source");
    chk_chop_swap: assert property (
        mode == MODE_CHOP && swapTick && !keyEvt && !knobEvt
        |=> reqValid && reqCode == REQ_SWAP)
        else $error("chop swap missing");
    chk_chop_knob: assert property (
        mode == MODE_CHOP && knobEvt && !keyEvt |=> mode == MODE_CHOP && $stable(presetName))
        else $error("knob acted in chop mode");

    cov_salvo_exec: cover property (reqValid && reqCode == REQ_EXEC);
    cov_chop_swap:  cover property (mode == MODE_CHOP && swapTick);
    cov_store:      cover property (mode == MODE_SALVO ##1 mode == MODE_STORE);
endmodule
`default_nettype wire

// ### verification/psc_router_model.sv
// Routing controller stand-in that logs every request from the panel.
`timescale 1ns/1ps
`default_nettype none
module psc_router_model
    import psc_pkg::*;
(
    // Clock
    input  wire logic        clk_sys,
    // Requests from the panel
    input  wire logic        reqValid,
    input  wire logic [2:0]  reqCode,
    input  wire logic [15:0] reqArg,
    // Request log
    output var  logic [2:0]  lastCode,
    output var  logic [15:0] lastArg,
    output var  int          nReq,
    output var  int          nSwap
);
    // Every request is accepted at once, so the bench sees exactly what the panel sent.
    initial begin
        lastCode = 3'h0;
        lastArg = 16'h0;
        nReq = 0;
        nSwap = 0;
    end
    always @(posedge clk_sys) begin
        if (reqValid === 1'b1) begin
            lastCode <= reqCode;
            lastArg  <= reqArg;
            nReq     <= nReq + 1;
            nSwap    <= nSwap + int'(reqCode === REQ_SWAP);
        end
    end
endmodule
`default_nettype wire

// ### verification/psc_ctrl_tb.sv
// Self-checking bench for the salvo and chop mode controller.
`timescale 1ns/1ps
`default_nettype none
module psc_ctrl_tb
    import psc_pkg::*;
;
    logic clk_sys, rstn, hsel, hwrite, hreadyout, hresp, keyEvt, knobEvt, addrHeld;
    logic reqValid, levelStep, presetBlink, levelLamp, guardLamp, guardBlink, lampAOn, lampBOn;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0]  htrans, destPrefix;
    logic [4:0]  keyType;
    logic [15:0] keyArg, reqArg, presetShow, lastArg;
    logic [15:0] names [8];
    logic [7:0]  pollAddr, lampKeyA, lampKeyB;
    logic [2:0]  reqCode, lastCode;
    int          nReq, nSwap, nStep, nMismatch, checked, seed, cyc;
    psc_ctrl #(.CHOP_COUNT(20)) dut (.clk_sys(clk_sys), .rstn(rstn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .keyEvt(keyEvt), .keyType(keyType), .keyArg(keyArg), .knobEvt(knobEvt),
        .addrHeld(addrHeld), .pollAddr(pollAddr), .reqValid(reqValid), .reqCode(reqCode),
        .reqArg(reqArg), .levelStep(levelStep), .presetShow(presetShow),
        .presetBlink(presetBlink), .levelLamp(levelLamp), .guardLamp(guardLamp),
        .guardBlink(guardBlink), .destPrefix(destPrefix), .lampKeyA(lampKeyA),
        .lampAOn(lampAOn), .lampKeyB(lampKeyB), .lampBOn(lampBOn));
    psc_router_model model (.clk_sys(clk_sys), .reqValid(reqValid), .reqCode(reqCode),
        .reqArg(reqArg), .lastCode(lastCode), .lastArg(lastArg), .nReq(nReq), .nSwap(nSwap));
    // ==========================================================
    // Clock, step counter and hang guard
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        nStep <= nStep + int'(levelStep === 1'b1);
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            nMismatch++;
            stop_test();
        end
    end
    // ==========================================================
    // Tasks and expectations
    function automatic logic [31:0] entry(input logic [15:0] n, input int i);
        return {14'h0, 1'(i != 0), 1'(i != 2), n};
    endfunction
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            nMismatch++;
            $display("BAD %0t %h %h", $time, s, e);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask
    task automatic mode(input logic [2:0] m);
        ahb(1'b0, OFS_CTRL, 32'h0);
        chk(32'(rd[2:0]), 32'(m));
    endtask
    task automatic key(input logic [4:0] t, input logic [15:0] a, input logic k);
        keyEvt <= ~k;
        knobEvt <= k;
        keyType <= t;
        keyArg <= a;
        @(posedge clk_sys);
        keyEvt <= 1'b0;
        knobEvt <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic stop_test();
        if (nMismatch == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    logic [4:0] xt [6] = '{KT_SRC, KT_DEST, KT_SOFTSALVO, FN_DEST, FN_SALVO, FN_PRESET};
    logic [2:0] xm [6] = '{MODE_DIRECT, MODE_DIRECT, MODE_DIRECT, MODE_DEST, MODE_SALVO,
                           MODE_PRESET};
    logic [2:0] xc [3] = '{REQ_TAKESRC, REQ_SETDEST, REQ_EXEC};
    initial begin
        {rstn, hsel, hwrite, keyEvt, knobEvt, addrHeld, haddr, hwdata, htrans} = '0;
        {keyType, keyArg, pollAddr, nStep, nMismatch, checked, cyc} = '0;
        seed = 92;
        repeat (8) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        ahb(1'b0, 8'hFC, 32'h0);
        chk(rd, RST_WORD);
        for (int i = 0; i < 8; i++) names[i] = 16'($random(seed));
        names[2] = ~names[1];
        names[3] = 16'hA53C;
        for (int i = 0; i < 8; i++) ahb(1'b1, OFS_SALVO0 + 8'(4 * i), entry(names[i], i));
        ahb(1'b1, OFS_CTRL, 32'(MODE_SALVO));
        key(5'h0, 16'h0, 1'b1);
        chk(presetShow, names[1]);
        key(5'h0, 16'h0, 1'b1);
        chk(presetShow, names[3]);
        key(KT_SALVO, names[2], 1'b0);
        key(FN_TAKE, 16'h0, 1'b0);
        chk({presetBlink, 31'(nReq)}, 32'h8000_0000);
        key(FN_STORE, 16'h0, 1'b0);
        mode(MODE_SALVO);
        key(KT_SALVO, names[1], 1'b0);
        key(FN_CHOP, 16'h0, 1'b0);
        chk({lastCode, lastArg}, {REQ_EXEC, names[1]});
        key(KT_SRC, 16'h1234, 1'b0);
        key(KT_DEDDEST, 16'h4321, 1'b0);
        chk({presetShow, 16'(nReq)}, {names[1], 16'h1});
        key(KT_CATIDX, 16'h00A5, 1'b0);
        key(KT_CATIDX, 16'h003C, 1'b0);
        chk({presetBlink, presetShow}, 32'hA53C);
        pollAddr <= 8'($random(seed));
        addrHeld <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk(presetShow, {8'h00, pollAddr});
        addrHeld <= 1'b0;
        key(FN_CLEAR, 16'h0, 1'b0);
        chk(presetShow, 32'h0);
        key(FN_LEVEL, 16'h0, 1'b0);
        key(5'h0, 16'h0, 1'b1);
        chk({levelLamp, presetShow, 15'(nStep)}, 32'h8000_0001);
        key(FN_LEVEL, 16'h0, 1'b0);
        key(KT_SOFTSALVO, names[3], 1'b0);
        key(FN_STORE, 16'h0, 1'b0);
        mode(MODE_STORE);
        ahb(1'b1, OFS_CTRL, 32'(MODE_SALVO));
        key(FN_DEST, 16'h0, 1'b0);
        mode(MODE_DEST);
        ahb(1'b1, OFS_CTRL, 32'(MODE_SALVO));
        key(FN_SALVO, 16'h0, 1'b0);
        mode(MODE_DIRECT);
        ahb(1'b1, OFS_CTRL, 32'(MODE_SALVO));
        key(FN_PRESET, 16'h0, 1'b0);
        mode(MODE_PRESET);
        ahb(1'b1, OFS_CHOPSRC, 32'h0135_0107);
        ahb(1'b1, OFS_CTRL, 32'(MODE_CHOP));
        key(FN_CLEAR, 16'h0, 1'b0);
        key(KT_CATIDX, 16'h0011, 1'b0);
        key(5'h0, 16'h0, 1'b1);
        mode(MODE_CHOP);
        chk({lampAOn, lampKeyA, lampBOn, lampKeyB}, 18'h20F35);
        repeat (65) @(posedge clk_sys);
        chk(32'(nSwap), 32'h3);
        key(FN_TAKE, 16'h0, 1'b0);
        mode(MODE_DIRECT);
        chk(32'(nSwap % 2), 32'h0);
        for (int j = 0; j < 6; j++) begin
            ahb(1'b1, OFS_CTRL, 32'(MODE_CHOP));
            key(xt[j], 16'h0200 + 16'(j), 1'b0);
            mode(xm[j]);
            if (j < 3) chk({lastCode, lastArg}, {xc[j], 16'h0200 + 16'(j)});
        end
        key(FN_PROT, 16'h0, 1'b0);
        chk({guardLamp, guardBlink, destPrefix, lastCode}, {2'b10, PFX_PROT, REQ_PROTECT});
        key(FN_LOCK, 16'h0, 1'b0);
        chk({guardLamp, guardBlink, destPrefix, lastCode}, {2'b11, PFX_LOCK, REQ_LOCK});
        stop_test();
    end
endmodule
`default_nettype wire
